//--- rtl/lec_ldo_enable_control.sv
// enable control for two linear regulators; discharge, mode and voltage control for regulator B only
// Functional notes
// (RL1) Regulator A pin selects count only with slot code 111 and software enable code 10.
// (RL2) Regulator A pin enable is the OR of all selected control pin levels.
// (RL3) Bit n of regulator A pin select includes control pin n when set, excludes it when clear.
// (RL4) Regulator B slot code 000 keeps it off, 001 enables it while supply is present.
// (RL5) Slot codes 010, 011, 100 enable regulator B at the 0, 25 and 50 percent boot points.
// (RL6) Slot code 111 lets regulator B follow its software enable after the 100 percent point.
// (RL7) Regulator B software enable 00 disables and 01 enables it.
// (RL8) Regulator B pin selects count only with slot code 111 and software enable code 10.
// (RL9) Each set bit of regulator B pin select adds that pin to an OR-ed enable.
// (RL10) Supply select bit 3 picks external input when clear, the always-on rail when set.
// (RL11) Active discharge bit 2 adds discharge while enable is low, hard reset always discharges.
// (RL12) The switch mode bit is latched and only follows the register while the regulator is off.
// (RL13) Passive discharge bit 0 adds discharge while enable is low, hard reset always applies.
// (RL14) The 5-bit voltage code maps to 0.9 V plus 0.1 V per step, up to 4 V.
// (RL15) Reserved slot codes and software enable code 11 leave the regulator disabled.
`timescale 1ns/10ps
module lec_ldo_enable_control
    import lec_pkg::*;
#(
    parameter int PIN_COUNT_A = 5,
    parameter int PIN_COUNT_B = 8
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // register port
    input  wire logic [7:0]             regAddr,
    input  wire logic                   regWrite,
    input  wire logic [7:0]             regWrData,
    output logic      [7:0]             regRdData,
    // boot sequencer and supply status
    input  wire logic                   supplyPresent,
    input  wire logic                   bootAt0,
    input  wire logic                   bootAt25,
    input  wire logic                   bootAt50,
    input  wire logic                   bootAt100,
    input  wire logic                   hardReset,
    // straps and fields of regulator A
    input  wire logic [2:0]             reg_a_boot_slot_code,
    input  wire logic [1:0]             reg_a_sw_enable_field,
    input  wire logic [PIN_COUNT_A-1:0] regAPinSelect,
    // strap of regulator B
    input  wire logic [2:0]             reg_b_boot_slot_code,
    // multipurpose control pins
    input  wire logic [PIN_COUNT_B-1:0] multipurpose_control_pin,
    // regulator A output
    output logic                        regAPinEnable,
    // regulator B outputs
    output logic                        regBEnable,
    output logic                        regBUseAlwaysOnRail,
    output logic                        regBActiveDischarge,
    output logic                        regBPassiveDischarge,
    output logic                        regBSwitchMode,
    output logic      [11:0]            regBVoutMillivolts
);
    // pin select register and write port are one byte wide
    if (PIN_COUNT_A < 1 || PIN_COUNT_A > PIN_COUNT_B || PIN_COUNT_B != 8) begin : g_bad_pins
        $error("unsupported pin counts");
    end

    typedef struct packed {
        logic                   seqCaptured;
        logic [2:0]             seqCode;
        logic [1:0]             swEnable;
        logic [3:0]             options;
        logic [4:0]             vCode;
        logic [PIN_COUNT_B-1:0] pinSel;
        logic                   modeLatched;
        logic                   enA;
        logic                   enB;
        logic                   actDsc;
        logic                   psvDsc;
        logic [7:0]             rdData;
        logic [11:0]            voutMv;
    } lec_state_t;

    lec_state_t state_reg;
    lec_state_t state_next;

    logic pinOrA;
    logic pinOrB;
    logic enBNext;

    always_comb begin
        state_next = state_reg;
        // the regulator B strap is caught at the first edge after reset release; regulator A's is read live
        if (!state_reg.seqCaptured) begin
            state_next.seqCaptured = 1'b1;
            state_next.seqCode     = reg_b_boot_slot_code;
        end
        if (regWrite) begin
            unique case (regAddr)
                LEC_OFS_ENABLE_CFG: begin
                    state_next.swEnable = regWrData[LEC_SW_MSB:LEC_SW_LSB];
                end
                LEC_OFS_OPTIONS: begin
                    state_next.options = regWrData[3:0];
                end
                LEC_OFS_VOLTAGE_CODE: begin
                    state_next.vCode = regWrData[LEC_VCODE_W-1:0];
                end
                LEC_OFS_PIN_SELECT: begin
                    state_next.pinSel = regWrData[PIN_COUNT_B-1:0];
                end
                default: begin
                end
            endcase
        end
        // pin-driven enables are the OR of selected pins
        pinOrA = |(regAPinSelect & multipurpose_control_pin[PIN_COUNT_A-1:0]); // [RL2] [RL3]
        pinOrB = |(state_reg.pinSel & multipurpose_control_pin); // [RL9]
        state_next.enA = (reg_a_boot_slot_code == LEC_SEQ_SW_CTRL)
                      && (reg_a_sw_enable_field == LEC_SW_PIN) && pinOrA; // [RL1]
        enBNext = 1'b0;
        if (state_reg.seqCaptured) begin
            unique case (lec_seq_t'(state_reg.seqCode))
                LEC_SEQ_OFF:    enBNext = 1'b0; // [RL4]
                LEC_SEQ_ALWAYS: enBNext = supplyPresent; // [RL4]
                LEC_SEQ_AT_0:   enBNext = bootAt0; // [RL5]
                LEC_SEQ_AT_25:  enBNext = bootAt25; // [RL5]
                LEC_SEQ_AT_50:  enBNext = bootAt50; // [RL5]
                LEC_SEQ_SW_CTRL: begin
                    unique case (lec_sw_t'(state_reg.swEnable))
                        LEC_SW_OFF:  enBNext = 1'b0; // [RL7]
                        LEC_SW_ON:   enBNext = bootAt100; // [RL6] [RL7]
                        LEC_SW_PIN:  enBNext = bootAt100 && pinOrB; // [RL8]
                        LEC_SW_RSVD: enBNext = 1'b0; // [RL15]
                    endcase
                end
                LEC_SEQ_RSVD5,
                LEC_SEQ_RSVD6:  enBNext = 1'b0; // [RL15]
            endcase
        end
        state_next.enB = enBNext;
        // mode only follows the register while the regulator is off
        if (!state_reg.enB) begin
            state_next.modeLatched = state_reg.options[LEC_BIT_MODE]; // [RL12]
        end
        state_next.actDsc = hardReset
                         || (state_reg.options[LEC_BIT_ACT_DSC] && !enBNext); // [RL11]
        state_next.psvDsc = hardReset
                         || (state_reg.options[LEC_BIT_PSV_DSC] && !enBNext); // [RL13]
        state_next.voutMv = LEC_VOUT_BASE_MV
                         + LEC_VOUT_STEP_MV * {7'h00, state_reg.vCode}; // [RL14]
        unique case (regAddr)
            LEC_OFS_ENABLE_CFG:   state_next.rdData = {state_reg.seqCode, 3'h0,
                                                       state_reg.swEnable};
            LEC_OFS_OPTIONS:      state_next.rdData = {4'h0, state_reg.options};
            LEC_OFS_VOLTAGE_CODE: state_next.rdData = {3'h0, state_reg.vCode};
            LEC_OFS_PIN_SELECT:   state_next.rdData = state_reg.pinSel;
            default:              state_next.rdData = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg.seqCaptured <= 1'b0;
            state_reg.seqCode     <= 3'h0;
            state_reg.swEnable    <= LEC_RST_SW_ENABLE;
            state_reg.options     <= LEC_RST_OPTIONS;
            state_reg.vCode       <= LEC_RST_VCODE;
            state_reg.pinSel      <= LEC_RST_PIN_SEL;
            state_reg.modeLatched <= 1'b0;
            state_reg.enA         <= 1'b0;
            state_reg.enB         <= 1'b0;
            state_reg.actDsc      <= 1'b0;
            state_reg.psvDsc      <= 1'b0;
            state_reg.rdData      <= 8'h00;
            state_reg.voutMv      <= LEC_VOUT_BASE_MV;
        end else begin
            state_reg <= state_next;
        end
    end

    assign regRdData            = state_reg.rdData;
    assign regAPinEnable        = state_reg.enA;
    assign regBEnable           = state_reg.enB;
    assign regBUseAlwaysOnRail  = state_reg.options[LEC_BIT_SUPPLY]; // [RL10]
    assign regBActiveDischarge  = state_reg.actDsc;
    assign regBPassiveDischarge = state_reg.psvDsc;
    assign regBSwitchMode       = state_reg.modeLatched;
    assign regBVoutMillivolts   = state_reg.voutMv;

    property p_a_gated;
        @(posedge clk) disable iff (!nrst)
        !(reg_a_boot_slot_code == 3'b111 && reg_a_sw_enable_field == 2'b10)
            |=> !regAPinEnable;
    endproperty
    a_a_gated: assert property (p_a_gated) else $error("pin A enable without valid codes"); // [RL1]

    property p_a_or;
        @(posedge clk) disable iff (!nrst)
        (reg_a_boot_slot_code == 3'b111 && reg_a_sw_enable_field == 2'b10)
            |=> regAPinEnable == $past(|(regAPinSelect
                                      & multipurpose_control_pin[PIN_COUNT_A-1:0]));
    endproperty
    a_a_or: assert property (p_a_or) else $error("pin A enable not OR of pins"); // [RL2]

    property p_b_off;
        @(posedge clk) disable iff (!nrst)
        (state_reg.seqCode == 3'b000 || state_reg.seqCode == 3'b101
         || state_reg.seqCode == 3'b110) |=> !regBEnable;
    endproperty
    a_b_off: assert property (p_b_off) else $error("regulator B on with off code"); // [RL4]

    property p_b_always;
        @(posedge clk) disable iff (!nrst)
        (state_reg.seqCaptured && state_reg.seqCode == 3'b001)
            |=> regBEnable == $past(supplyPresent);
    endproperty
    a_b_always: assert property (p_b_always) else $error("supply enable wrong"); // [RL4]

    property p_b_boot25;
        @(posedge clk) disable iff (!nrst)
        (state_reg.seqCaptured && state_reg.seqCode == 3'b011)
            |=> regBEnable == $past(bootAt25);
    endproperty
    a_b_boot25: assert property (p_b_boot25) else $error("25 percent point ignored"); // [RL5]

    property p_b_sw;
        @(posedge clk) disable iff (!nrst)
        (state_reg.seqCode == 3'b111 && !bootAt100) |=> !regBEnable;
    endproperty
    a_b_sw: assert property (p_b_sw) else $error("enabled before 100 percent"); // [RL6]

    property p_b_reserved;
        @(posedge clk) disable iff (!nrst)
        (state_reg.swEnable == 2'b11 || state_reg.swEnable == 2'b00) |=> !regBEnable
            || $past(state_reg.seqCode) != 3'b111;
    endproperty
    a_b_reserved: assert property (p_b_reserved) else $error("reserved enable on"); // [RL15]

    property p_mode_hold;
        @(posedge clk) disable iff (!nrst)
        regBEnable |=> $stable(regBSwitchMode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed while on"); // [RL12]

    property p_act_dsc;
        @(posedge clk) disable iff (!nrst)
        (state_reg.options[LEC_BIT_ACT_DSC] && !regBEnable && !hardReset)
            ##1 !regBEnable |-> regBActiveDischarge;
    endproperty
    a_act_dsc: assert property (p_act_dsc) else $error("no active discharge"); // [RL11]

    property p_psv_hr;
        @(posedge clk) disable iff (!nrst)
        hardReset |=> regBPassiveDischarge && regBActiveDischarge;
    endproperty
    a_psv_hr: assert property (p_psv_hr) else $error("no discharge in hard reset"); // [RL13]

    property p_vout;
        @(posedge clk) disable iff (!nrst)
        $past(state_reg.vCode) == 5'h1F && $stable(state_reg.vCode)
            |-> regBVoutMillivolts == 12'hFA0;
    endproperty
    a_vout: assert property (p_vout) else $error("full scale not 4 V"); // [RL14]
endmodule

//--- rtl/lec_pkg.sv
// constants for the regulator enable and configuration block
package lec_pkg;
    // register offsets
    localparam logic [7:0] LEC_OFS_ENABLE_CFG   = 8'h55;
    localparam logic [7:0] LEC_OFS_OPTIONS      = 8'h56;
    localparam logic [7:0] LEC_OFS_VOLTAGE_CODE = 8'h57;
    localparam logic [7:0] LEC_OFS_PIN_SELECT   = 8'h58;
    // field positions
    localparam int LEC_SEQ_MSB        = 7;
    localparam int LEC_SEQ_LSB        = 5;
    localparam int LEC_SW_MSB         = 1;
    localparam int LEC_SW_LSB         = 0;
    localparam int LEC_BIT_SUPPLY     = 3;
    localparam int LEC_BIT_ACT_DSC    = 2;
    localparam int LEC_BIT_MODE       = 1;
    localparam int LEC_BIT_PSV_DSC    = 0;
    localparam int LEC_VCODE_W        = 5;
    // values after reset
    localparam logic [1:0] LEC_RST_SW_ENABLE = 2'h0;
    localparam logic [3:0] LEC_RST_OPTIONS   = 4'h0;
    localparam logic [4:0] LEC_RST_VCODE     = 5'h00;
    localparam logic [7:0] LEC_RST_PIN_SEL   = 8'h00;
    // output voltage scale in millivolts
    localparam logic [11:0] LEC_VOUT_BASE_MV = 12'h384;
    localparam logic [11:0] LEC_VOUT_STEP_MV = 12'h064;

    // boot slot codes
    typedef enum logic [2:0] {
        LEC_SEQ_OFF     = 3'b000,
        LEC_SEQ_ALWAYS  = 3'b001,
        LEC_SEQ_AT_0    = 3'b010,
        LEC_SEQ_AT_25   = 3'b011,
        LEC_SEQ_AT_50   = 3'b100,
        LEC_SEQ_RSVD5   = 3'b101,
        LEC_SEQ_RSVD6   = 3'b110,
        LEC_SEQ_SW_CTRL = 3'b111
    } lec_seq_t;

    // software enable codes
    typedef enum logic [1:0] {
        LEC_SW_OFF  = 2'b00,
        LEC_SW_ON   = 2'b01,
        LEC_SW_PIN  = 2'b10,
        LEC_SW_RSVD = 2'b11
    } lec_sw_t;
endpackage

//--- sim/lec_boot_model.sv
// boot sequencer model: raises the boot points one at a time and holds them
`timescale 1ns/10ps
module lec_boot_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // last point to reach, 0 for none up to 4 for the 100 percent point
    input  wire logic [2:0] stage,
    // points reached: 0, 25, 50 and 100 percent
    output logic      [3:0] bootAt
);
    logic [2:0] levelReg;

    // one point per cycle, never skipping, cleared only by reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            levelReg <= 3'h0;
        end else if (levelReg < stage) begin
            levelReg <= levelReg + 3'h1;
        end
    end

    always_comb begin
        for (int k = 0; k < 4; k++) begin
            bootAt[k] = (levelReg > 3'(k));
        end
    end
endmodule

//--- sim/lec_ldo_enable_control_bench.sv
// self-checking bench for the regulator enable and configuration block
`timescale 1ns/10ps
module lec_ldo_enable_control_bench;
    import lec_pkg::*;
    logic        clk, nrst, regWrite, supplyPresent, hardReset;
    logic [7:0]  regAddr, regWrData, regRdData, ctrlPins;
    logic [2:0]  seqA, seqB, stage;
    logic [1:0]  swA;
    logic [4:0]  pinSelA;
    logic [3:0]  bootAt;
    logic        enA, enB, aonRail, actDsc, psvDsc, swMode;
    logic [11:0] vout;
    int          badCount, comparisons, cycles;
    logic [4:0]  codes [4] = '{5'h00, 5'h01, 5'h1E, 5'h1F};

    lec_boot_model i_boot (.clk(clk), .nrst(nrst), .stage(stage), .bootAt(bootAt));

    lec_ldo_enable_control i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
        .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
        .supplyPresent(supplyPresent), .bootAt0(bootAt[0]), .bootAt25(bootAt[1]),
        .bootAt50(bootAt[2]), .bootAt100(bootAt[3]), .hardReset(hardReset),
        .reg_a_boot_slot_code(seqA), .reg_a_sw_enable_field(swA),
        .regAPinSelect(pinSelA), .reg_b_boot_slot_code(seqB),
        .multipurpose_control_pin(ctrlPins), .regAPinEnable(enA), .regBEnable(enB),
        .regBUseAlwaysOnRail(aonRail), .regBActiveDischarge(actDsc),
        .regBPassiveDischarge(psvDsc), .regBSwitchMode(swMode),
        .regBVoutMillivolts(vout));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a hang counts as a mismatch and closes the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            complete_run();
        end
    end

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        regAddr = a;
        @(negedge clk);
        chk({4'h0, regRdData}, {4'h0, e});
    endtask

    task automatic settle;
        repeat (6) @(negedge clk);
    endtask

    task automatic restart(input logic [2:0] s);
        @(negedge clk);
        nrst = 1'b0;
        seqB = s;
        stage = 3'h0;
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
    endtask

    // enable of regulator B with software enable 01 at a given boot point
    function automatic logic expB(input logic [2:0] s, input logic [2:0] st);
        case (s)
            3'b001: return supplyPresent;
            3'b010: return st >= 3'h1;
            3'b011: return st >= 3'h2;
            3'b100: return st >= 3'h3;
            3'b111: return st >= 3'h4;
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        {nrst, regWrite, hardReset, regAddr, regWrData, ctrlPins} = '0;
        {seqA, swA, pinSelA, seqB, stage, badCount, comparisons, cycles} = '0;
        supplyPresent = 1'b1;
        restart(3'b111);
        chk(vout, 12'h384);
        rd(LEC_OFS_ENABLE_CFG, 8'hE0);
        rd(LEC_OFS_PIN_SELECT, 8'h00);
        wr(LEC_OFS_OPTIONS, 8'hFF);
        rd(LEC_OFS_OPTIONS, 8'h0F);
        chk(aonRail, 1'b1);
        wr(LEC_OFS_VOLTAGE_CODE, 8'hFF);
        rd(LEC_OFS_VOLTAGE_CODE, 8'h1F);
        wr(8'h59, 8'hFF);
        rd(8'h59, 8'h00);
        wr(LEC_OFS_ENABLE_CFG, 8'hFF);
        rd(LEC_OFS_ENABLE_CFG, 8'hE3);
        for (int s = 0; s < 8; s++) begin
            restart(3'(s));
            wr(LEC_OFS_ENABLE_CFG, 8'h01);
            for (int st = 0; st < 5; st++) begin
                stage = 3'(st);
                settle();
                chk(enB, expB(3'(s), 3'(st)));
            end
        end
        wr(LEC_OFS_ENABLE_CFG, 8'h03);
        settle();
        chk(enB, 1'b0);
        wr(LEC_OFS_ENABLE_CFG, 8'h02);
        wr(LEC_OFS_PIN_SELECT, 8'hA5);
        for (int i = 0; i < 8; i++) begin
            ctrlPins = 8'h01 << i;
            settle();
            chk(enB, 8'hA5 >> i & 8'h01);
        end
        ctrlPins = 8'h5A;
        settle();
        chk(enB, 1'b0);
        ctrlPins = 8'h24;
        settle();
        chk(enB, 1'b1);
        wr(LEC_OFS_ENABLE_CFG, 8'h00);
        wr(LEC_OFS_OPTIONS, 8'h05);
        settle();
        chk({enB, actDsc, psvDsc, aonRail}, 4'h6);
        wr(LEC_OFS_ENABLE_CFG, 8'h01);
        settle();
        chk({enB, actDsc, psvDsc}, 3'h4);
        hardReset = 1'b1;
        settle();
        chk({actDsc, psvDsc}, 2'h3);
        hardReset = 1'b0;
        wr(LEC_OFS_OPTIONS, 8'h02);
        settle();
        chk({enB, swMode, actDsc}, 3'h4);
        wr(LEC_OFS_ENABLE_CFG, 8'h00);
        settle();
        chk(swMode, 1'b1);
        wr(LEC_OFS_ENABLE_CFG, 8'h01);
        wr(LEC_OFS_OPTIONS, 8'h00);
        settle();
        chk(swMode, 1'b1);
        foreach (codes[c]) begin
            wr(LEC_OFS_VOLTAGE_CODE, {3'h0, codes[c]});
            settle();
            chk(vout, 12'h384 + 12'h064 * codes[c]);
        end
        restart(3'b001);
        supplyPresent = 1'b0;
        settle();
        chk(enB, 1'b0);
        pinSelA = 5'b10110;
        for (int s = 6; s < 8; s++) begin
            for (int w = 0; w < 4; w++) begin
                for (int i = 0; i < 5; i++) begin
                    seqA = 3'(s);
                    swA = 2'(w);
                    ctrlPins = 8'h01 << i;
                    settle();
                    chk(enA, s == 7 && w == 2 && pinSelA[i]);
                end
            end
        end
        swA = 2'b10;
        ctrlPins = 8'hE9;
        settle();
        chk(enA, 1'b0);
        ctrlPins = 8'h06;
        settle();
        chk(enA, 1'b1);
        complete_run();
    end
endmodule
